// ### dop_pkg.sv
// Purpose: Constants and types for the DNP3 outstation protocol handler.
// Assumes: 125 MHz clock, classic Wishbone register access.
// Notes: Overview of operation follows.
// Overview of operation
// R1: Serial characters are 8 data, no parity, one stop.
// R2: Line rate selectable 9600, 19200, 38400, 57600.
// R3: Master frames arrive with direction and primary set.
// R4: Responses go out with direction clear, primary set.
// R5: Acknowledgments go out with direction and primary clear.
// R6: Confirmed traffic needs link reset; unconfirmed always allowed.
// R7: Confirmed data: acknowledge first, then unconfirmed reply.
// R8: Unconfirmed data: reply unconfirmed, no acknowledgment.
// R9: Station address 0 to 247, plus all-stations 65535.
// R10: Transport header must mark first and final.
// R11: Application control must mark first and final.
// R12: Read honoured on outputs, counters, analogs, class.
// R13: Binary output variation 0 answered as variation 2.
// R14: Counter variation 0 answered as variation 4.
// R15: Write accepted only on internal indications object.
// R16: Direct operate point 0 clears energy, strict settings.
// R17: No-ack operate point 1 switches to Modbus, strict.
// R18: Every application reply uses response function 129.
// R19: Output point 0 reads 1 during energy reset.
// R20: Output point 1 reads 1 open, 0 energized.
// R21: Modbus switch leaves stored setting; reset restores DNP.
// R22: Only the listed objects and variations are supported.
// R23: Analog input variation 0 answered as variation 5.
// R24: Class 0 returns analogs, counters, outputs headers.
// R25: Restart bit set on reset, cleared by write.
// R26: Frames for other addresses are silently dropped.
// R27: Unsupported requests rejected without any state change.
package dop_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int DIVW = 14;
  localparam logic [DIVW-1:0] DIV_9600 = DIVW'((CLK_HZ + 4800) / 9600);
  localparam logic [DIVW-1:0] DIV_19200 = DIVW'((CLK_HZ + 9600) / 19200);
  localparam logic [DIVW-1:0] DIV_38400 = DIVW'((CLK_HZ + 19200) / 38400);
  localparam logic [DIVW-1:0] DIV_57600 = DIVW'((CLK_HZ + 28800) / 57600);
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STS = 8'h04;
  localparam logic [7:0] REG_CNT = 8'h08;
  localparam logic [7:0] MAX_STATION = 8'hf7;
  localparam logic [15:0] BCAST = 16'hffff;
  localparam logic [7:0] SYNC0 = 8'h05;
  localparam logic [7:0] SYNC1 = 8'h64;
  localparam logic [7:0] LINK_HDR_LEN = 8'h05;
  localparam logic [7:0] CTRL_ACK = 8'h00;
  localparam logic [7:0] CTRL_RSP = 8'h44;
  localparam logic [3:0] LF_RESET = 4'h0;
  localparam logic [3:0] LF_CONF = 4'h3;
  localparam logic [3:0] LF_UNCONF = 4'h4;
  localparam logic [7:0] AF_READ = 8'h01;
  localparam logic [7:0] AF_WRITE = 8'h02;
  localparam logic [7:0] AF_DOP = 8'h05;
  localparam logic [7:0] AF_DOPNA = 8'h06;
  localparam logic [7:0] AF_RSP = 8'h81;
  localparam logic [7:0] G_BO = 8'h0a;
  localparam logic [7:0] G_CROB = 8'h0c;
  localparam logic [7:0] G_CNT = 8'h14;
  localparam logic [7:0] G_AI = 8'h1e;
  localparam logic [7:0] G_CLASS = 8'h3c;
  localparam logic [7:0] G_IIN = 8'h50;
  localparam logic [7:0] Q_RANGE = 8'h00;
  localparam logic [7:0] Q_CNT8 = 8'h17;
  localparam logic [7:0] CROB_CODE = 8'h01;
  localparam logic [31:0] CROB_ON = 32'h0000_0001;
  localparam logic [7:0] IIN2_FUNC = 8'h01;
  localparam logic [7:0] IIN2_OBJ = 8'h02;
  localparam logic [7:0] IIN2_PARAM = 8'h04;
  localparam logic [39:0] HDR_BO = 40'h0a_02_00_00_01;
  localparam logic [39:0] HDR_CNT = 40'h14_04_00_00_04;
  localparam logic [39:0] HDR_AI = 40'h1e_05_00_00_1f;
  localparam logic [15:0] CRC_POLY = 16'ha6bc;
  localparam int RXD_DEPTH = 24;
  localparam int BLK = 16;

  typedef struct packed {
    logic [1:0] baud;
    logic [7:0] station;
  } dop_cfg_t;

  typedef struct packed {
    logic modbus;
    logic ebusy;
    logic link_ok;
    logic restart;
  } dop_sts_t;

  localparam dop_cfg_t CFG_RST = '{baud: 2'h0, station: 8'h01};

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b11,
    SER_STOP = 2'b10
  } dop_ser_t;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_HDR = 2'b01,
    TS_DAT = 2'b11
  } dop_ts_t;

  typedef enum logic [2:0] {
    RK_NULL = 3'd0,
    RK_BO = 3'd1,
    RK_CNT = 3'd2,
    RK_AI = 3'd3,
    RK_C0 = 3'd4
  } dop_kind_t;
endpackage

// ### dop_outstation.sv
// Purpose: DNP3 outstation link, transport and application handler on RS485.
// Assumes: Half duplex bus; master waits for the reply before polling again.
// Notes: Point values come from elsewhere; replies carry object headers, plus the two output point states.
`timescale 1ns/1ps
module dop_outstation
  import dop_pkg::*;
#(
  parameter int RXD = RXD_DEPTH,
  parameter int CLK_FREQ = CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic tx_en_o,
  input wire logic energy_done_i,
  output logic energy_clr_o,
  output logic modbus_mode_o
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Rounded to nearest so every rate stays within a fraction of a cycle
  function automatic logic [DIVW-1:0] baud_div(input int rate);
    return DIVW'((CLK_FREQ + rate / 2) / rate);
  endfunction

  function automatic logic [7:0] hdr_byte(input logic [39:0] h, input logic [4:0] j);
    return h[8*(4-j) +: 8];
  endfunction

  function automatic logic [7:0] rsp_len(input dop_kind_t k);
    unique case (k)
      RK_BO: return 8'd12;
      RK_CNT: return 8'd10;
      RK_AI: return 8'd10;
      RK_C0: return 8'd22;
      default: return 8'd5;
    endcase
  endfunction

  logic ack_ff;
  logic [31:0] dat_ff;
  dop_cfg_t cfg_ff;
  dop_sts_t sts_ff;
  logic [15:0] frm_cnt_ff;
  logic [2:0] rx_s_ff;
  logic rx_lvl_ff;
  dop_ser_t rs_ff;
  logic [DIVW-1:0] rcnt_ff;
  logic [2:0] rbit_ff;
  logic [7:0] rsh_ff;
  logic rvld_ff;
  logic [3:0] pos_ff;
  logic [7:0] len_ff;
  logic [7:0] ctl_ff;
  logic [15:0] dst_ff;
  logic [15:0] src_ff;
  logic [4:0] dcnt_ff;
  logic [4:0] blk_ff;
  logic crc1_ff;
  logic done_ff;
  logic [7:0] rx_d_ff [RXD];
  dop_ts_t ts_ff;
  logic [3:0] tpos_ff;
  logic [4:0] tdc_ff;
  logic [4:0] tblk_ff;
  logic [1:0] tcp_ff;
  logic [15:0] tcrc_ff;
  logic t_isdat_ff;
  logic t_pend_ff;
  logic [15:0] t_dst_ff;
  dop_kind_t t_kind_ff;
  logic [7:0] t_iin2_ff;
  logic [3:0] t_aseq_ff;
  logic [5:0] t_seq_ff;
  dop_ser_t tu_ff;
  logic [DIVW-1:0] tcnt_ff;
  logic [2:0] tbit_ff;
  logic [7:0] tsh_ff;
  logic tbusy_ff;
  logic tx_ff;
  logic txen_ff;

  logic wb_req;
  logic cfg_wr;
  logic [DIVW-1:0] bit_div;
  logic [7:0] ndata;
  logic hit;
  logic bcast;
  logic app_ok;
  logic crob_ok;
  logic go_ack;
  logic go_app;
  logic reply;
  logic a_link;
  logic a_clr;
  logic a_eng;
  logic a_mb;
  dop_kind_t kind;
  logic [7:0] iin2;
  logic ld;
  logic [7:0] tbyte;
  logic [4:0] tnd;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // Write lands on the edge at which the master sees ack high
  assign cfg_wr = ce_i & wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & (wb_adr_i[7:0] == REG_CFG);

  // Register bus: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else if (ce_i) begin
      ack_ff <= wb_req;
      if (wb_req) begin
        unique case (wb_adr_i[7:0])
          REG_CFG: dat_ff <= {22'h0, cfg_ff.baud, cfg_ff.station};
          REG_STS: dat_ff <= {28'h0, sts_ff};
          REG_CNT: dat_ff <= {16'h0, frm_cnt_ff};
          default: dat_ff <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_RST;
    end else if (cfg_wr) begin
      // Out-of-range station values are dropped, old address kept
      if (wb_sel_i[0] && wb_dat_i[7:0] <= MAX_STATION) begin
        cfg_ff.station <= wb_dat_i[7:0]; // R9
      end
      if (wb_sel_i[1]) begin
        cfg_ff.baud <= wb_dat_i[9:8]; // R2
      end
    end
  end

  always_comb begin
    unique case (cfg_ff.baud)
      2'd0: bit_div = baud_div(9600); // R2
      2'd1: bit_div = baud_div(19200);
      2'd2: bit_div = baud_div(38400);
      default: bit_div = baud_div(57600);
    endcase
  end

  // Bus pin: three stages, level moves once the last two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s_ff <= 3'b111;
      rx_lvl_ff <= 1'b1;
    end else if (ce_i) begin
      rx_s_ff <= {rx_s_ff[1:0], rx_i};
      if (rx_s_ff[1] == rx_s_ff[2]) begin
        rx_lvl_ff <= rx_s_ff[2];
      end
    end
  end

  // Character receiver, sampled mid-bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs_ff <= SER_IDLE;
      rcnt_ff <= '0;
      rbit_ff <= 3'h0;
      rsh_ff <= 8'h0;
      rvld_ff <= 1'b0;
    end else if (ce_i) begin
      rvld_ff <= 1'b0;
      if (rs_ff != SER_IDLE && rcnt_ff != '0) begin
        rcnt_ff <= rcnt_ff - 1'b1;
      end else begin
        unique case (rs_ff)
          SER_IDLE: if (!rx_lvl_ff) begin
            rcnt_ff <= bit_div >> 1;
            rs_ff <= SER_START;
          end
          SER_START: begin
            rcnt_ff <= bit_div - 1'b1;
            rbit_ff <= 3'h0;
            rs_ff <= rx_lvl_ff ? SER_IDLE : SER_DATA;
          end
          SER_DATA: begin
            rsh_ff <= {rx_lvl_ff, rsh_ff[7:1]}; // R1
            rcnt_ff <= bit_div - 1'b1;
            rbit_ff <= rbit_ff + 1'b1;
            if (rbit_ff == 3'd7) begin
              rs_ff <= SER_STOP;
            end
          end
          SER_STOP: begin
            rvld_ff <= rx_lvl_ff; // R1
            rs_ff <= SER_IDLE;
          end
        endcase
      end
    end
  end

  assign ndata = len_ff - LINK_HDR_LEN;

  // Frame collector; a broken sync pattern restarts the hunt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_ff <= 4'h0;
      len_ff <= 8'h0;
      ctl_ff <= 8'h0;
      dst_ff <= 16'h0;
      src_ff <= 16'h0;
      dcnt_ff <= 5'h0;
      blk_ff <= 5'h0;
      crc1_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce_i) begin
      done_ff <= 1'b0;
      if (rvld_ff) begin
        pos_ff <= pos_ff + 1'b1;
        unique case (pos_ff)
          4'd0: if (rsh_ff != SYNC0) pos_ff <= 4'd0;
          4'd1: if (rsh_ff != SYNC1) pos_ff <= (rsh_ff == SYNC0) ? 4'd1 : 4'd0;
          4'd2: begin
            len_ff <= rsh_ff;
            if (rsh_ff < LINK_HDR_LEN) pos_ff <= 4'd0;
          end
          4'd3: ctl_ff <= rsh_ff;
          4'd4: dst_ff[7:0] <= rsh_ff;
          4'd5: dst_ff[15:8] <= rsh_ff;
          4'd6: src_ff[7:0] <= rsh_ff;
          4'd7: src_ff[15:8] <= rsh_ff;
          4'd8: ;
          4'd9: begin
            dcnt_ff <= 5'h0;
            blk_ff <= 5'h0;
            crc1_ff <= 1'b0;
            if (ndata == 8'h0) begin
              done_ff <= 1'b1;
              pos_ff <= 4'd0;
            end
          end
          default: begin
            pos_ff <= 4'd10;
            if (!crc1_ff && blk_ff != 5'(BLK) && {3'h0, dcnt_ff} != ndata) begin
              if (int'(dcnt_ff) < RXD) rx_d_ff[dcnt_ff] <= rsh_ff;
              dcnt_ff <= dcnt_ff + 1'b1;
              blk_ff <= blk_ff + 1'b1;
            end else if (!crc1_ff) begin
              crc1_ff <= 1'b1;
            end else begin
              crc1_ff <= 1'b0;
              blk_ff <= 5'h0;
              if ({3'h0, dcnt_ff} == ndata) begin
                done_ff <= 1'b1;
                pos_ff <= 4'd0;
              end
            end
          end
        endcase
      end
    end
  end

  assign bcast = dst_ff == BCAST;
  assign hit = (dst_ff == {8'h00, cfg_ff.station}) | bcast; // R9 R26
  assign app_ok = (ndata >= 8'd6) && (rx_d_ff[0][7:6] == 2'b11) // R10
                  && (rx_d_ff[1][7:6] == 2'b11); // R11
  assign crob_ok = (rx_d_ff[3] == G_CROB) && (rx_d_ff[4] == 8'h01) && (rx_d_ff[5] == Q_CNT8)
                   && (rx_d_ff[6] == 8'h01) && (rx_d_ff[8] == CROB_CODE) && (rx_d_ff[9] == 8'h01)
                   && ({rx_d_ff[13], rx_d_ff[12], rx_d_ff[11], rx_d_ff[10]} == CROB_ON)
                   && ({rx_d_ff[17], rx_d_ff[16], rx_d_ff[15], rx_d_ff[14]} == 32'h0);

  // Request decode; frames arriving mid-transmit are lost
  always_comb begin
    go_ack = 1'b0;
    go_app = 1'b0;
    reply = 1'b0;
    a_link = 1'b0;
    a_clr = 1'b0;
    a_eng = 1'b0;
    a_mb = 1'b0;
    kind = RK_NULL;
    iin2 = 8'h0;
    if (done_ff && hit && ctl_ff[7] && ctl_ff[6] && !sts_ff.modbus && ts_ff == TS_IDLE) begin // R3
      unique case (ctl_ff[3:0])
        LF_RESET: begin
          a_link = 1'b1; // R6
          go_ack = ~bcast;
        end
        LF_CONF: if (sts_ff.link_ok) begin // R6
          go_ack = ~bcast; // R7
          go_app = 1'b1;
        end
        LF_UNCONF: go_app = 1'b1; // R6 R8
        default: ;
      endcase
    end
    if (go_app && app_ok) begin
      reply = ~bcast;
      unique case (rx_d_ff[2])
        AF_READ: begin
          unique case (rx_d_ff[3]) // R12 R22
            G_BO: if (rx_d_ff[4] == 8'h0 || rx_d_ff[4] == 8'h2) kind = RK_BO; // R13
                  else iin2 = IIN2_OBJ;
            G_CNT: if (rx_d_ff[4] == 8'h0 || rx_d_ff[4] == 8'h4) kind = RK_CNT; // R14
                   else iin2 = IIN2_OBJ;
            G_AI: if (rx_d_ff[4] == 8'h0 || rx_d_ff[4] == 8'h5) kind = RK_AI; // R23
                  else iin2 = IIN2_OBJ;
            G_CLASS: if (rx_d_ff[4] == 8'h0 || rx_d_ff[4] == 8'h1) kind = RK_C0; // R24
                     else iin2 = IIN2_OBJ;
            default: iin2 = IIN2_OBJ; // R27
          endcase
        end
        AF_WRITE: begin
          if (rx_d_ff[3] == G_IIN && rx_d_ff[4] == 8'h01 && rx_d_ff[5] == Q_RANGE // R15
              && rx_d_ff[6] == 8'h0 && rx_d_ff[7] == 8'h0 && !rx_d_ff[8][0]) begin
            a_clr = 1'b1; // R25
          end else begin
            iin2 = IIN2_PARAM; // R27
          end
        end
        AF_DOP: if (crob_ok && rx_d_ff[7] == 8'h0) a_eng = 1'b1; // R16
                else iin2 = IIN2_PARAM; // R27
        AF_DOPNA: begin
          reply = 1'b0;
          if (crob_ok && rx_d_ff[7] == 8'h1) a_mb = 1'b1; // R17
        end
        default: iin2 = IIN2_FUNC; // R27
      endcase
    end
  end

  // Protocol state; setting always beats clearing in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_ff <= '{modbus: 1'b0, ebusy: 1'b0, link_ok: 1'b0, restart: 1'b1}; // R25 R21
      frm_cnt_ff <= 16'h0;
    end else if (ce_i) begin
      if (a_link) sts_ff.link_ok <= 1'b1;
      else if (cfg_wr) sts_ff.link_ok <= 1'b0; // R6
      if (a_clr) sts_ff.restart <= 1'b0; // R25
      if (a_eng) sts_ff.ebusy <= 1'b1; // R16 R19
      else if (energy_done_i) sts_ff.ebusy <= 1'b0;
      if (a_mb) sts_ff.modbus <= 1'b1; // R17 R21
      if (go_ack || go_app || a_link) frm_cnt_ff <= frm_cnt_ff + 1'b1;
    end
  end

  assign energy_clr_o = sts_ff.ebusy;
  assign modbus_mode_o = sts_ff.modbus;

  assign tnd = 5'(rsp_len(t_kind_ff));

  // Outgoing byte; the body is rebuilt from latched request facts
  always_comb begin
    tbyte = 8'h00;
    if (ts_ff == TS_HDR) begin
      unique case (tpos_ff)
        4'd0: tbyte = SYNC0;
        4'd1: tbyte = SYNC1;
        4'd2: tbyte = LINK_HDR_LEN + (t_isdat_ff ? {3'h0, tnd} : 8'h0);
        4'd3: tbyte = t_isdat_ff ? CTRL_RSP : CTRL_ACK; // R4 R5
        4'd4: tbyte = t_dst_ff[7:0];
        4'd5: tbyte = t_dst_ff[15:8];
        4'd6: tbyte = cfg_ff.station;
        4'd7: tbyte = 8'h00;
        4'd8: tbyte = ~tcrc_ff[7:0];
        default: tbyte = ~tcrc_ff[15:8];
      endcase
    end else if (tcp_ff == 2'd1) begin
      tbyte = ~tcrc_ff[7:0];
    end else if (tcp_ff == 2'd2) begin
      tbyte = ~tcrc_ff[15:8];
    end else begin
      unique case (tdc_ff)
        5'd0: tbyte = {2'b11, t_seq_ff}; // R10
        5'd1: tbyte = {4'hc, t_aseq_ff}; // R11
        5'd2: tbyte = AF_RSP; // R18
        5'd3: tbyte = {sts_ff.restart, 7'h0}; // R25
        5'd4: tbyte = t_iin2_ff;
        default: begin
          unique case (t_kind_ff)
            RK_CNT: tbyte = hdr_byte(HDR_CNT, tdc_ff - 5'd5);
            RK_AI: tbyte = hdr_byte(HDR_AI, tdc_ff - 5'd5);
            RK_BO: tbyte = (tdc_ff < 5'd10) ? hdr_byte(HDR_BO, tdc_ff - 5'd5)
                         : (tdc_ff == 5'd10) ? {sts_ff.ebusy, 7'h01} // R19
                         : {~sts_ff.modbus, 7'h01}; // R20
            RK_C0: tbyte = (tdc_ff < 5'd10) ? hdr_byte(HDR_AI, tdc_ff - 5'd5) // R24
                         : (tdc_ff < 5'd15) ? hdr_byte(HDR_CNT, tdc_ff - 5'd10)
                         : (tdc_ff < 5'd20) ? hdr_byte(HDR_BO, tdc_ff - 5'd15)
                         : (tdc_ff == 5'd20) ? {sts_ff.ebusy, 7'h01}
                         : {~sts_ff.modbus, 7'h01};
            default: tbyte = 8'h00;
          endcase
        end
      endcase
    end
  end

  assign ld = (ts_ff != TS_IDLE) & ~tbusy_ff;

  // Frame sequencer: acknowledgment first, queued reply after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_ff <= TS_IDLE;
      tpos_ff <= 4'h0;
      tdc_ff <= 5'h0;
      tblk_ff <= 5'h0;
      tcp_ff <= 2'h0;
      tcrc_ff <= 16'h0;
      t_isdat_ff <= 1'b0;
      t_pend_ff <= 1'b0;
      t_dst_ff <= 16'h0;
      t_kind_ff <= RK_NULL;
      t_iin2_ff <= 8'h0;
      t_aseq_ff <= 4'h0;
      t_seq_ff <= 6'h0;
    end else if (ce_i) begin
      if (go_ack || reply) begin
        ts_ff <= TS_HDR;
        tpos_ff <= 4'h0;
        t_isdat_ff <= ~go_ack; // R8
        t_pend_ff <= go_ack & reply; // R7
        t_dst_ff <= src_ff;
        t_kind_ff <= kind;
        t_iin2_ff <= iin2;
        t_aseq_ff <= rx_d_ff[1][3:0];
      end else if (ld) begin
        if (ts_ff == TS_HDR ? tpos_ff == 4'd9 : tcp_ff == 2'd2) tcrc_ff <= 16'h0;
        else if (ts_ff == TS_HDR ? tpos_ff < 4'd8 : tcp_ff == 2'd0) tcrc_ff <= crc_step(tcrc_ff, tbyte);
        if (ts_ff == TS_HDR) begin
          tpos_ff <= tpos_ff + 1'b1;
          tdc_ff <= 5'h0;
          tblk_ff <= 5'h0;
          tcp_ff <= 2'h0;
          if (tpos_ff == 4'd9) begin
            if (t_isdat_ff) ts_ff <= TS_DAT;
            else if (t_pend_ff) begin
              t_pend_ff <= 1'b0;
              t_isdat_ff <= 1'b1;
              tpos_ff <= 4'h0;
            end else ts_ff <= TS_IDLE;
          end
        end else if (tcp_ff == 2'd0) begin
          tdc_ff <= tdc_ff + 1'b1;
          tblk_ff <= tblk_ff + 1'b1;
          if (tdc_ff + 5'd1 == tnd || tblk_ff == 5'(BLK - 1)) tcp_ff <= 2'd1;
        end else if (tcp_ff == 2'd1) begin
          tcp_ff <= 2'd2;
        end else begin
          tcp_ff <= 2'd0;
          tblk_ff <= 5'h0;
          if (tdc_ff == tnd) begin
            ts_ff <= TS_IDLE;
            t_seq_ff <= t_seq_ff + 1'b1;
          end
        end
      end
    end
  end

  // Character transmitter, 8N1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tu_ff <= SER_IDLE;
      tcnt_ff <= '0;
      tbit_ff <= 3'h0;
      tsh_ff <= 8'h0;
      tbusy_ff <= 1'b0;
      tx_ff <= 1'b1;
      txen_ff <= 1'b0;
    end else if (ce_i) begin
      txen_ff <= (ts_ff != TS_IDLE) | tbusy_ff;
      if (tu_ff == SER_IDLE) begin
        if (ld) begin
          tsh_ff <= tbyte;
          tbusy_ff <= 1'b1;
          tu_ff <= SER_START;
          tcnt_ff <= bit_div - 1'b1;
          tx_ff <= 1'b0; // R1
        end
      end else if (tcnt_ff != '0) begin
        tcnt_ff <= tcnt_ff - 1'b1;
      end else begin
        tcnt_ff <= bit_div - 1'b1;
        unique case (tu_ff)
          SER_START: begin
            tx_ff <= tsh_ff[0];
            tsh_ff <= tsh_ff >> 1;
            tbit_ff <= 3'h0;
            tu_ff <= SER_DATA;
          end
          SER_DATA: begin
            tbit_ff <= tbit_ff + 1'b1;
            tx_ff <= (tbit_ff == 3'd7) ? 1'b1 : tsh_ff[0]; // R1
            tsh_ff <= tsh_ff >> 1;
            if (tbit_ff == 3'd7) tu_ff <= SER_STOP;
          end
          default: begin
            tbusy_ff <= 1'b0;
            tu_ff <= SER_IDLE;
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign tx_o = tx_ff;
  assign tx_en_o = txen_ff;
endmodule

// ### dop_outstation_assertions.sv
// Purpose: Port checks for the outstation.
// Assumes: One clock, sync reset.
// Notes: Bound into every outstation.
`timescale 1ns/1ps
module dop_outstation_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_o,
  input wire logic tx_en_o,
  input wire logic energy_done_i,
  input wire logic energy_clr_o,
  input wire logic modbus_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_latency: assert property (s_req |=> s_ans)
    else $error("ack not one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_tx_idle: assert property (!tx_en_o |-> tx_o)
    else $error("line not idle high");
  chk_start_bit: assert property ($rose(tx_en_o) |-> ##[0:1] !tx_o)
    else $error("no start bit");
  chk_stop_bit: assert property ($fell(tx_en_o) |-> $past(tx_o))
    else $error("frame ended off stop level");
  chk_rst_state: assert property ($fell(rst_i) |-> !modbus_mode_o && !energy_clr_o)
    else $error("reset left a mode active");
  chk_modbus_hold: assert property (modbus_mode_o |=> modbus_mode_o)
    else $error("modbus mode dropped");
  chk_energy_hold: assert property (energy_clr_o && !energy_done_i |=> energy_clr_o)
    else $error("energy busy dropped early");
endmodule
bind dop_outstation dop_outstation_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_o(tx_o),
  .tx_en_o(tx_en_o), .energy_done_i(energy_done_i), .energy_clr_o(energy_clr_o),
  .modbus_mode_o(modbus_mode_o));

// ### dop_master_model.sv
// Purpose: Polling master on the serial bus.
// Assumes: Bus biased high when released.
// Notes: Request checksums are not formed.
`timescale 1ns/1ps
module dop_master_model #(
  parameter int DIV = 2170
) (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    line_o <= 1'b0;
    repeat (DIV) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (DIV) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (DIV) @(posedge clk_i);
  endtask
  // Samples mid-bit, so a late start edge still reads clean
  task automatic recv_byte(output logic [7:0] b, output logic stp);
    while (tx_i !== 1'b0) @(posedge clk_i);
    repeat (DIV / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk_i);
      b[i] = tx_i;
    end
    repeat (DIV) @(posedge clk_i);
    stp = tx_i;
  endtask
endmodule

// ### dop_outstation_test.sv
// Purpose: Register and link tests of the outstation.
// Assumes: Link at 57600 against a scaled clock rate, so bit times stay short.
// Notes: Link reset, operate with reply, protocol switch, then a second reset.
`timescale 1ns/1ps
module dop_outstation_test;
  import dop_pkg::*;
  localparam int SIM_HZ = 2_304_000;
  localparam int BDIV = (SIM_HZ + 28800) / 57600;
  logic clk_i, rst_i, ce_i, cyc, stb, we, e_done, rx, ack, tx, tx_en, stp, e_clr, mbm;
  logic [31:0] adr, dat, rdat, q;
  logic [3:0] sel;
  logic [7:0] b;
  int n_fail, num_checks, cyc_n;
  logic [7:0] lr[10] = '{8'h05, 8'h64, 8'h05, 8'hc0, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  logic [7:0] ak[8] = '{8'h05, 8'h64, 8'h05, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00};
  logic [7:0] op[32] = '{8'h05, 8'h64, 8'h17, 8'hc4, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00,
    8'h00, 8'hc0, 8'hc0, 8'h05, 8'h0c, 8'h01, 8'h17, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rp[15] = '{8'h05, 8'h64, 8'h0a, 8'h44, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00,
    8'h00, 8'hc0, 8'hc0, 8'h81, 8'h80, 8'h00};
  dop_outstation #(.CLK_FREQ(SIM_HZ)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_i(rx), .tx_o(tx), .tx_en_o(tx_en),
    .energy_done_i(e_done), .energy_clr_o(e_clr), .modbus_mode_o(mbm));
  dop_master_model #(.DIV(BDIV)) m (.clk_i(clk_i), .tx_i(tx), .line_o(rx));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h0, a};
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, e);
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling covers about a hundred bytes on the wire plus margin
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    dat = 32'h0;
    sel = 4'h0;
    e_done = 1'b0;
    n_fail = 0;
    num_checks = 0;
    cyc_n = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_CFG, 32'h001);
    rd(REG_STS, 32'h1);
    rd(REG_CNT, 32'h0);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, REG_CFG, {22'h0, 2'(r), 8'hf7}, 4'h3);
      rd(REG_CFG, {22'h0, 2'(r), 8'hf7});
    end
    bus(1'b1, REG_CFG, 32'h0f8, 4'h1);
    rd(REG_CFG, 32'h3f7);
    bus(1'b1, 8'h10, 32'hffff_ffff, 4'hf);
    rd(8'h10, 32'h0);
    bus(1'b1, REG_CFG, 32'h301, 4'h3);
    @(posedge clk_i);
    fork
      foreach (lr[i]) m.send_byte(lr[i]);
      foreach (ak[i]) begin
        m.recv_byte(b, stp);
        chk(b, ak[i]);
        chk(stp, 1'b1);
      end
    join
    while (tx_en !== 1'b0) @(posedge clk_i);
    rd(REG_STS, 32'h3);
    rd(REG_CNT, 32'h1);
    bus(1'b1, REG_CFG, 32'h301, 4'h3);
    rd(REG_STS, 32'h1);
    fork
      foreach (op[i]) m.send_byte(op[i]);
      foreach (rp[i]) begin
        m.recv_byte(b, stp);
        if (i != 8 && i != 9) chk(b, rp[i]);
      end
    join
    while (tx_en !== 1'b0) @(posedge clk_i);
    chk(e_clr, 1'b1);
    rd(REG_STS, 32'h5);
    e_done <= 1'b1;
    @(posedge clk_i);
    e_done <= 1'b0;
    @(posedge clk_i);
    chk(e_clr, 1'b0);
    op[12] = 8'h06;
    op[17] = 8'h01;
    foreach (op[i]) m.send_byte(op[i]);
    repeat (2) @(posedge clk_i);
    chk(mbm, 1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(mbm, 1'b0);
    rd(REG_STS, 32'h1);
    complete_run();
  end
endmodule
